/* File: dgic_pkg.sv */
package dgic_pkg;
    // ==========================================
    // Register map, byte addresses
    localparam logic [63:0] CTRL_BASE      = 64'h0000_0000_100B_0000;
    localparam logic [63:0] CTRL_SPAN      = 64'h0000_0000_0000_4000;
    localparam logic [63:0] GUARD_BASE     = 64'h0000_0000_100B_8000;
    localparam logic [63:0] GUARD_SPAN     = 64'h0000_0000_0000_1000;
    localparam logic [63:0] MEM_BASE       = 64'h0000_0000_8000_0000;
    localparam logic [63:0] MEM_SPAN       = 64'h0000_0020_0000_0000;
    localparam logic [13:0] OFS_START_CLS  = 14'h0000;
    localparam logic [13:0] OFS_INT_STATUS = 14'h0210;
    localparam logic [13:0] OFS_INT_MASK   = 14'h0220;
    localparam logic [11:0] OFS_GUARD      = 12'h000;
    // ==========================================
    // Field layouts and reset values
    localparam int          START_BIT      = 0;
    localparam int          CLASS_LSB      = 8;
    localparam int          CLASS_MSB      = 11;
    localparam logic [31:0] CTRL_WMASK     = 32'h0000_0F01;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
    localparam logic [3:0]  CLASS_GEN3     = 4'h6;
    localparam logic [3:0]  CLASS_GEN4     = 4'hA;
    localparam int          ST_PORT_ERR    = 7;
    localparam int          ST_INIT_DONE   = 8;
    localparam int          LIMIT_MSB      = 53;
    localparam int          EN_LSB         = 56;
    localparam int          EN_MSB         = 59;
    localparam logic [63:0] GUARD_WMASK    = 64'h0F3F_FFFF_FFFF_FFFF;
    localparam logic [63:0] GUARD_RESET    = 64'h0000_0000_0000_0000;
    localparam logic [3:0]  GUARD_EN_VAL   = 4'hF;
    // ==========================================
    // TileLink opcodes
    localparam logic [2:0]  TL_PUT_FULL    = 3'h0;
    localparam logic [2:0]  TL_PUT_PART    = 3'h1;
    localparam logic [2:0]  TL_GET         = 3'h4;
    localparam logic [2:0]  TL_ACK         = 3'h0;
    localparam logic [2:0]  TL_ACK_DATA    = 3'h1;
    // ==========================================
    // DFI command codes and timing
    localparam logic [1:0]  DFI_NOP        = 2'h0;
    localparam logic [1:0]  DFI_RD         = 2'h1;
    localparam logic [1:0]  DFI_WR         = 2'h2;
    localparam logic [1:0]  DFI_REF        = 2'h3;
    localparam int          CLK_PERIOD_NS  = 20;
    localparam int          REFI_NS        = 7800;
    localparam int          REFI_CYC       = REFI_NS / CLK_PERIOD_NS;
    localparam int          MAX_RATE_MTS   = 2400;
    localparam int          CLK_DIV        = 4;
    // ==========================================
    // Memory path states
    typedef enum logic [2:0] {
        M_IDLE = 3'b001,
        M_RD   = 3'b010,
        M_RSP  = 3'b100
    } dgic_mem_e;
endpackage

/* File: dgic_top.sv */
`timescale 1ns/1ps
module dgic_top #(
    parameter int RANKS = 1,
    parameter int RATE_MTS = 2400
) (
    // Clock, reset, enable
    input  wire logic         core_clk,
    input  wire logic         resetn,
    input  wire logic         ce,
    // Memory port, channel A
    input  wire logic         mem_a_valid,
    output logic              mem_a_ready,
    input  wire logic [2:0]   mem_a_opcode,
    input  wire logic [2:0]   mem_a_size,
    input  wire logic [7:0]   mem_a_source,
    input  wire logic [63:0]  mem_a_address,
    input  wire logic [31:0]  mem_a_mask,
    input  wire logic [255:0] mem_a_data,
    // Memory port, channel D
    output logic              mem_d_valid,
    input  wire logic         mem_d_ready,
    output logic [2:0]        mem_d_opcode,
    output logic [2:0]        mem_d_size,
    output logic [7:0]        mem_d_source,
    output logic              mem_d_denied,
    output logic [255:0]      mem_d_data,
    // Guard register port
    input  wire logic         grd_a_valid,
    output logic              grd_a_ready,
    input  wire logic [2:0]   grd_a_opcode,
    input  wire logic [2:0]   grd_a_size,
    input  wire logic [7:0]   grd_a_source,
    input  wire logic [63:0]  grd_a_address,
    input  wire logic [7:0]   grd_a_mask,
    input  wire logic [63:0]  grd_a_data,
    output logic              grd_d_valid,
    input  wire logic         grd_d_ready,
    output logic [2:0]        grd_d_opcode,
    output logic [2:0]        grd_d_size,
    output logic [7:0]        grd_d_source,
    output logic              grd_d_denied,
    output logic [63:0]       grd_d_data,
    // Controller register port
    input  wire logic         cfg_a_valid,
    output logic              cfg_a_ready,
    input  wire logic [2:0]   cfg_a_opcode,
    input  wire logic [2:0]   cfg_a_size,
    input  wire logic [7:0]   cfg_a_source,
    input  wire logic [63:0]  cfg_a_address,
    input  wire logic [7:0]   cfg_a_mask,
    input  wire logic [63:0]  cfg_a_data,
    output logic              cfg_d_valid,
    input  wire logic         cfg_d_ready,
    output logic [2:0]        cfg_d_opcode,
    output logic [2:0]        cfg_d_size,
    output logic [7:0]        cfg_d_source,
    output logic              cfg_d_denied,
    output logic [63:0]       cfg_d_data,
    // DFI toward the PHY
    output logic [1:0]        dfi_cmd,
    output logic [63:0]       dfi_address,
    output logic [255:0]      dfi_wrdata,
    output logic [31:0]       dfi_wrmask,
    input  wire logic         dfi_rddata_valid,
    input  wire logic [255:0] dfi_rddata,
    output logic              dfi_init_start,
    input  wire logic         dfi_init_complete,
    output logic [3:0]        dram_class,
    // Interrupt
    output logic              irq
);
    import dgic_pkg::*;

    // ==========================================
    // Elaboration checks
    if (RANKS < 1 || RANKS > 2) begin : g_ranks_chk
        $error("RANKS must be 1 or 2");
    end
    if (RATE_MTS > MAX_RATE_MTS) begin : g_rate_chk
        $error("RATE_MTS above supported rate");
    end

    // Byte-lane merge of write data
    function automatic logic [63:0] wmerge(input logic [63:0] old, input logic [63:0] nw, input logic [7:0] m);
        logic [63:0] r;
        r = old;
        for (int i = 0; i < 8; i++) begin
            if (m[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    // ==========================================
    // Guard register and lock
    logic [63:0] guard_q;
    logic        locked_q;
    logic [63:0] g_new;
    logic        guard_on;
    logic        grd_take;
    logic        grd_hit;
    logic        grd_wr;
    assign guard_on = (guard_q[EN_MSB:EN_LSB] == GUARD_EN_VAL);
    assign grd_a_ready = ce && !grd_d_valid;
    assign grd_take = grd_a_valid && grd_a_ready;
    assign grd_hit = (grd_a_address >= GUARD_BASE) && (grd_a_address < GUARD_BASE + GUARD_SPAN);
    assign grd_wr = grd_a_opcode != TL_GET;
    assign g_new = wmerge(guard_q, grd_a_data, grd_a_mask) & GUARD_WMASK;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            guard_q  <= GUARD_RESET;
            locked_q <= 1'b0;
        end else if (ce && grd_take && grd_hit && grd_wr && !locked_q
                     && grd_a_address[11:0] == OFS_GUARD) begin
            guard_q <= g_new;
            if ((g_new[EN_MSB:EN_LSB] == GUARD_EN_VAL) != guard_on) begin
                locked_q <= 1'b1;
            end
        end
    end

    // Guard port answer
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            grd_d_valid  <= 1'b0;
            grd_d_opcode <= TL_ACK;
            grd_d_size   <= 3'h0;
            grd_d_source <= 8'h00;
            grd_d_denied <= 1'b0;
            grd_d_data   <= 64'h0;
        end else if (ce) begin
            if (grd_take) begin
                grd_d_valid  <= 1'b1;
                grd_d_opcode <= grd_wr ? TL_ACK : TL_ACK_DATA;
                grd_d_size   <= grd_a_size;
                grd_d_source <= grd_a_source;
                grd_d_denied <= !grd_hit;
                grd_d_data   <= (grd_hit && !grd_wr && grd_a_address[11:0] == OFS_GUARD) ? guard_q : 64'h0;
            end else if (grd_d_ready) begin
                grd_d_valid <= 1'b0;
            end
        end
    end

    // ==========================================
    // Controller registers
    logic [31:0] ctrl_q;
    logic [31:0] status_q;
    logic [31:0] mask_q;
    logic        start_prev_q;
    logic        train_q;
    logic        cfg_take;
    logic        cfg_hit;
    logic        cfg_wr;
    logic [13:0] cfg_ofs;
    logic [31:0] cfg_wdat;
    logic [31:0] st_set;
    logic        refused_ev;
    assign cfg_a_ready = ce && !cfg_d_valid;
    assign cfg_take = cfg_a_valid && cfg_a_ready;
    assign cfg_hit = (cfg_a_address >= CTRL_BASE) && (cfg_a_address < CTRL_BASE + CTRL_SPAN);
    assign cfg_wr = cfg_a_opcode != TL_GET;
    assign cfg_ofs = cfg_a_address[13:0];
    assign cfg_wdat = 32'(wmerge(64'h0, cfg_a_data, cfg_a_mask & 8'h0F));
    assign dram_class = ctrl_q[CLASS_MSB:CLASS_LSB];
    assign dfi_init_start = train_q;

    // Start and class register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= CTRL_RESET;
        end else if (ce && cfg_take && cfg_hit && cfg_wr && cfg_ofs == OFS_START_CLS) begin
            ctrl_q <= 32'(wmerge({32'h0, ctrl_q}, cfg_a_data, cfg_a_mask)) & CTRL_WMASK;
        end
    end

    // Training launch on rising start
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            start_prev_q <= 1'b0;
            train_q      <= 1'b0;
        end else if (ce) begin
            start_prev_q <= ctrl_q[START_BIT];
            if (ctrl_q[START_BIT] && !start_prev_q) begin
                train_q <= 1'b1;
            end else if (dfi_init_complete) begin
                train_q <= 1'b0;
            end
        end
    end

    // Sticky status, set wins over write-one-to-clear
    assign st_set = ({31'h0, train_q && dfi_init_complete} << ST_INIT_DONE)
                  | ({31'h0, refused_ev} << ST_PORT_ERR);
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            status_q <= 32'h0;
            mask_q   <= 32'h0;
        end else if (ce) begin
            if (cfg_take && cfg_hit && cfg_wr && cfg_ofs == OFS_INT_STATUS) begin
                status_q <= (status_q & ~cfg_wdat) | st_set;
            end else begin
                status_q <= status_q | st_set;
            end
            if (cfg_take && cfg_hit && cfg_wr && cfg_ofs == OFS_INT_MASK) begin
                mask_q <= 32'(wmerge({32'h0, mask_q}, cfg_a_data, cfg_a_mask));
            end
        end
    end

    // Single interrupt line
    assign irq = |(status_q & ~mask_q);

    // Controller port answer
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_d_valid  <= 1'b0;
            cfg_d_opcode <= TL_ACK;
            cfg_d_size   <= 3'h0;
            cfg_d_source <= 8'h00;
            cfg_d_denied <= 1'b0;
            cfg_d_data   <= 64'h0;
        end else if (ce) begin
            if (cfg_take) begin
                cfg_d_valid  <= 1'b1;
                cfg_d_opcode <= cfg_wr ? TL_ACK : TL_ACK_DATA;
                cfg_d_size   <= cfg_a_size;
                cfg_d_source <= cfg_a_source;
                cfg_d_denied <= !cfg_hit;
                if (!cfg_hit || cfg_wr) cfg_d_data <= 64'h0;
                else if (cfg_ofs == OFS_START_CLS) cfg_d_data <= {32'h0, ctrl_q};
                else if (cfg_ofs == OFS_INT_STATUS) cfg_d_data <= {32'h0, status_q};
                else if (cfg_ofs == OFS_INT_MASK) cfg_d_data <= {32'h0, mask_q};
                else cfg_d_data <= 64'h0;
            end else if (cfg_d_ready) begin
                cfg_d_valid <= 1'b0;
            end
        end
    end

    // ==========================================
    // Memory path with range guard and DFI issue
    dgic_mem_e   mst_q;
    logic [15:0] ref_cnt_q;
    logic        ref_pend;
    logic        ref_due;
    logic        mem_take;
    logic        mem_refuse;
    logic        mem_inwin;
    logic        mem_wr;
    // A due refresh waits for the idle state so it is never lost mid-transfer
    assign ref_pend = (ref_cnt_q == 16'(REFI_CYC - 1));
    assign ref_due = ref_pend && status_q[ST_INIT_DONE] && (mst_q == M_IDLE);
    assign mem_inwin = (mem_a_address >= MEM_BASE) && (mem_a_address < MEM_BASE + MEM_SPAN);
    assign mem_refuse = !mem_inwin || !guard_on
                      || (mem_a_address[55:2] > guard_q[LIMIT_MSB:0]);
    assign mem_wr = mem_a_opcode != TL_GET;
    assign mem_a_ready = ce && (mst_q == M_IDLE) && !ref_due;
    assign mem_take = mem_a_valid && mem_a_ready;
    assign refused_ev = ce && mem_take && mem_refuse;
    assign mem_d_valid = (mst_q == M_RSP);

    // Refresh interval counter
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ref_cnt_q <= 16'h0;
        end else if (ce) begin
            if (ref_due || !status_q[ST_INIT_DONE]) begin
                ref_cnt_q <= 16'h0;
            end else if (!ref_pend) begin
                ref_cnt_q <= ref_cnt_q + 16'h1;
            end
        end
    end

    // Request sequencing
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mst_q        <= M_IDLE;
            dfi_cmd      <= DFI_NOP;
            dfi_address  <= 64'h0;
            dfi_wrdata   <= 256'h0;
            dfi_wrmask   <= 32'h0;
            mem_d_opcode <= TL_ACK;
            mem_d_size   <= 3'h0;
            mem_d_source <= 8'h00;
            mem_d_denied <= 1'b0;
            mem_d_data   <= 256'h0;
        end else if (ce) begin
            dfi_cmd <= DFI_NOP;
            case (mst_q)
                M_IDLE: begin
                    if (ref_due) begin
                        dfi_cmd <= DFI_REF;
                    end else if (mem_take) begin
                        mem_d_opcode <= mem_wr ? TL_ACK : TL_ACK_DATA;
                        mem_d_size   <= mem_a_size;
                        mem_d_source <= mem_a_source;
                        mem_d_denied <= mem_refuse;
                        mem_d_data   <= 256'h0;
                        if (mem_refuse) begin
                            mst_q <= M_RSP;
                        end else begin
                            dfi_cmd     <= mem_wr ? DFI_WR : DFI_RD;
                            dfi_address <= mem_a_address;
                            dfi_wrdata  <= mem_a_data;
                            dfi_wrmask  <= mem_a_mask;
                            mst_q       <= mem_wr ? M_RSP : M_RD;
                        end
                    end
                end
                M_RD: begin
                    if (dfi_rddata_valid) begin
                        mem_d_data <= dfi_rddata;
                        mst_q      <= M_RSP;
                    end
                end
                M_RSP: begin
                    if (mem_d_ready) mst_q <= M_IDLE;
                end
                default: mst_q <= M_IDLE;
            endcase
        end
    end

    // ==========================================
    // Checks
    refuse_no_cmd_a: assert property (@(posedge core_clk) disable iff (!resetn)
        refused_ev |=> dfi_cmd == DFI_NOP && mem_d_valid && mem_d_denied)
        else $error("refused request reached DFI");
    guard_above_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (ce && mem_take && guard_on && mem_a_address[55:2] > guard_q[LIMIT_MSB:0]) |=> mem_d_denied)
        else $error("request above limit not refused");
    lock_holds_a: assert property (@(posedge core_clk) disable iff (!resetn)
        locked_q |=> $stable(guard_q) && locked_q)
        else $error("guard changed after lock");
    guard_resv_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (guard_q & ~GUARD_WMASK) == 64'h0)
        else $error("guard reserved bits set");
    start_train_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (ce && $rose(ctrl_q[START_BIT])) |=> train_q)
        else $error("start did not launch training");
    done_sets_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (ce && train_q && dfi_init_complete) |=> status_q[ST_INIT_DONE])
        else $error("init done flag missed");
    irq_mask_a: assert property (@(posedge core_clk) disable iff (!resetn)
        refused_ev |=> irq || mask_q[ST_PORT_ERR])
        else $error("unmasked cause did not raise interrupt");
    refresh_cmd_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (ce && ref_due) |-> !mem_a_ready ##1 dfi_cmd == DFI_REF)
        else $error("refresh not issued");
    read_wait_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (ce && mem_take && !mem_refuse && !mem_wr) |=> mst_q == M_RD && !mem_d_valid)
        else $error("read answered before data");
endmodule

/* File: dgic_phy_model.sv */
`timescale 1ns/1ps
// ==========================================
// PHY stand-in: answers reads and training
module dgic_phy_model #(
    parameter int INIT_CYC = 20
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         resetn,
    // Commands from the controller
    input  wire logic [1:0]   dfi_cmd,
    input  wire logic [63:0]  dfi_address,
    input  wire logic         dfi_init_start,
    // Answers toward the controller
    output logic              dfi_rddata_valid,
    output logic [255:0]      dfi_rddata,
    output logic              dfi_init_complete
);
    import dgic_pkg::*;
    logic [7:0]  wait_q;
    logic        slow_q;
    logic [63:0] addr_q;
    logic [7:0]  init_q;
    // Read return, latency alternates short and long
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wait_q           <= 8'h00;
            slow_q           <= 1'b0;
            addr_q           <= '0;
            dfi_rddata_valid <= 1'b0;
            dfi_rddata       <= '0;
        end else begin
            dfi_rddata_valid <= 1'b0;
            dfi_rddata       <= ~dfi_rddata;  // Idle data never holds still
            if (dfi_cmd == DFI_RD) begin
                wait_q <= slow_q ? 8'h06 : 8'h01;
                slow_q <= ~slow_q;
                addr_q <= dfi_address;
            end else if (wait_q == 8'h01) begin
                dfi_rddata_valid <= 1'b1;
                dfi_rddata       <= {4{addr_q ^ 64'h5A5A_5A5A_5A5A_5A5A}};
                wait_q           <= 8'h00;
            end else if (wait_q != 8'h00) begin
                wait_q <= wait_q - 8'h01;
            end
        end
    end
    // Training completes a fixed time after start
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            init_q            <= 8'h00;
            dfi_init_complete <= 1'b0;
        end else begin
            dfi_init_complete <= 1'b0;
            if (!dfi_init_start) begin
                init_q <= 8'h00;
            end else if (init_q == INIT_CYC[7:0]) begin
                dfi_init_complete <= 1'b1;
                init_q            <= 8'h00;
            end else begin
                init_q <= init_q + 8'h01;
            end
        end
    end
endmodule

/* File: dgic_top_bench.sv */
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin mismatches++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, s); end end
module dgic_top_bench;
    import dgic_pkg::*;
    logic         core_clk, resetn, ce, rdy, irq, m_av, m_ar, m_dv, m_den, rd_v, init_st, init_ok;
    logic [2:0]   m_op;
    logic [7:0]   src, bm;
    logic [1:0]   dfi_cmd, cmd_seen;
    logic [3:0]   dram_class;
    logic [63:0]  m_ad, dfi_address, adr_seen, q, lim;
    logic [255:0] m_wd, m_rd, dfi_wrdata, rd_data, mq, wd_seen;
    logic         r_av[2], r_ar[2], r_dv[2], r_den[2], den;
    logic [2:0]   r_op[2], r_dop[2], dop;
    logic [63:0]  r_ad[2], r_wd[2], r_rd[2];
    int           mismatches, checks_done;
    // ==========================================
    // Design, PHY stand-in, clock
    dgic_top dut (
        .core_clk(core_clk), .resetn(resetn), .ce(ce),
        .mem_a_valid(m_av), .mem_a_ready(m_ar), .mem_a_opcode(m_op), .mem_a_size(3'h5), .mem_a_source(src),
        .mem_a_address(m_ad), .mem_a_mask({4{bm}}), .mem_a_data(m_wd), .mem_d_valid(m_dv), .mem_d_ready(rdy),
        .mem_d_opcode(), .mem_d_size(), .mem_d_source(), .mem_d_denied(m_den), .mem_d_data(m_rd),
        .grd_a_valid(r_av[1]), .grd_a_ready(r_ar[1]), .grd_a_opcode(r_op[1]), .grd_a_size(3'h3),
        .grd_a_source(src), .grd_a_address(r_ad[1]), .grd_a_mask(bm), .grd_a_data(r_wd[1]),
        .grd_d_valid(r_dv[1]), .grd_d_ready(rdy), .grd_d_opcode(r_dop[1]), .grd_d_size(), .grd_d_source(),
        .grd_d_denied(r_den[1]), .grd_d_data(r_rd[1]),
        .cfg_a_valid(r_av[0]), .cfg_a_ready(r_ar[0]), .cfg_a_opcode(r_op[0]), .cfg_a_size(3'h3),
        .cfg_a_source(src), .cfg_a_address(r_ad[0]), .cfg_a_mask(bm), .cfg_a_data(r_wd[0]),
        .cfg_d_valid(r_dv[0]), .cfg_d_ready(rdy), .cfg_d_opcode(r_dop[0]), .cfg_d_size(), .cfg_d_source(),
        .cfg_d_denied(r_den[0]), .cfg_d_data(r_rd[0]),
        .dfi_cmd(dfi_cmd), .dfi_address(dfi_address), .dfi_wrdata(dfi_wrdata), .dfi_wrmask(),
        .dfi_rddata_valid(rd_v), .dfi_rddata(rd_data), .dfi_init_start(init_st),
        .dfi_init_complete(init_ok), .dram_class(dram_class), .irq(irq)
    );
    dgic_phy_model phy (
        .core_clk(core_clk), .resetn(resetn), .dfi_cmd(dfi_cmd), .dfi_address(dfi_address),
        .dfi_init_start(init_st), .dfi_rddata_valid(rd_v), .dfi_rddata(rd_data), .dfi_init_complete(init_ok)
    );
    // Free-running core clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // ==========================================
    // Bus tasks
    task automatic step();
        @(posedge core_clk);
        #1;
    endtask
    // Register port transfer: p 0 controller, 1 guard
    task automatic racc(input int p, input bit wr, input logic [63:0] a, d);
        r_av[p] = 1'b1;
        r_op[p] = wr ? TL_PUT_FULL : TL_GET;
        r_ad[p] = a;
        r_wd[p] = d;
        src = src + 8'h01;
        for (int i = 0; i < 20 && r_ar[p] !== 1'b1; i++) step();
        step();
        r_av[p] = 1'b0;
        for (int i = 0; i < 20 && r_dv[p] !== 1'b1; i++) step();
        q = r_rd[p];
        den = r_den[p];
        dop = r_dop[p];
        step();
    endtask
    // Memory port transfer, command snapshot on the cycle after taking
    task automatic macc(input bit wr, input logic [63:0] a, input logic [255:0] d);
        m_av = 1'b1;
        m_op = wr ? TL_PUT_FULL : TL_GET;
        m_ad = a;
        m_wd = d;
        src = src + 8'h01;
        for (int i = 0; i < 20 && m_ar !== 1'b1; i++) step();
        step();
        m_av = 1'b0;
        cmd_seen = dfi_cmd;
        adr_seen = dfi_address;
        wd_seen = dfi_wrdata;
        for (int i = 0; i < 40 && m_dv !== 1'b1; i++) step();
        mq = m_rd;
        den = m_den;
        step();
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset();
        racc(1, 0, GUARD_BASE, '0);
        `CHK("guard reset", GUARD_RESET, q)
        `CHK("guard read opcode", TL_ACK_DATA, dop)
        racc(0, 0, CTRL_BASE, '0);
        `CHK("control reset", 64'h0, q)
        `CHK("control read opcode", TL_ACK_DATA, dop)
        `CHK("irq idle", 1'b0, irq)
    endtask
    task automatic t_closed();
        macc(0, MEM_BASE, '0);
        `CHK("closed denied", 1'b1, den)
        `CHK("closed command", DFI_NOP, cmd_seen)
        `CHK("closed data", 256'h0, mq)
        racc(0, 0, CTRL_BASE + 64'(OFS_INT_STATUS), '0);
        `CHK("error flag", 64'h80, q)
        `CHK("irq raised", 1'b1, irq)
        racc(0, 1, CTRL_BASE + 64'(OFS_INT_MASK), 64'h80);
        `CHK("irq masked", 1'b0, irq)
        racc(0, 1, CTRL_BASE + 64'(OFS_INT_STATUS), 64'h80);
        `CHK("control write opcode", TL_ACK, dop)
        racc(0, 0, CTRL_BASE + 64'(OFS_INT_STATUS), '0);
        `CHK("flag cleared", 64'h0, q)
        racc(0, 1, CTRL_BASE + 64'(OFS_INT_MASK), '0);
    endtask
    task automatic t_init();
        logic [3:0] cls [2];
        cls = '{CLASS_GEN3, CLASS_GEN4};
        foreach (cls[i]) begin
            racc(0, 1, CTRL_BASE, {52'hFFFF_FFFF_FFFF_F, cls[i], 8'hFE});
            racc(0, 0, CTRL_BASE, '0);
            `CHK("class readback", {52'h0, cls[i], 8'h00}, q)
            `CHK("class output", cls[i], dram_class)
        end
        `CHK("no training yet", 1'b0, init_st)
        racc(0, 1, CTRL_BASE, {52'h0, CLASS_GEN4, 8'h01});
        for (int i = 0; i < 10 && init_st !== 1'b1; i++) step();
        `CHK("training launched", 1'b1, init_st)
        q = '0;
        for (int i = 0; i < 50 && q[8] !== 1'b1; i++) racc(0, 0, CTRL_BASE + 64'(OFS_INT_STATUS), '0);
        `CHK("init done flag", 64'h100, q)
        `CHK("training ended", 1'b0, init_st)
        `CHK("irq on done", 1'b1, irq)
        racc(0, 1, CTRL_BASE + 64'(OFS_INT_MASK), 64'h100);
        `CHK("done masked", 1'b0, irq)
    endtask
    task automatic t_refresh();
        int t0;
        int n;
        t0 = 0;
        n = 0;
        for (int i = 0; i < 900 && n < 2; i++) begin
            step();
            if (dfi_cmd === DFI_REF) begin
                if (n == 1) `CHK("refresh gap", REFI_CYC, i - t0)
                t0 = i;
                n++;
            end
        end
        `CHK("refresh count", 2, n)
    endtask
    task automatic t_guard();
        logic [63:0] ra [2];
        lim = (MEM_BASE + 64'h10_0000 - 64'h4) >> 2;
        racc(1, 1, GUARD_BASE, lim);
        racc(1, 0, GUARD_BASE, '0);
        `CHK("limit stored", lim, q)
        racc(1, 1, GUARD_BASE, 64'hFFC0_0000_0000_0000 | lim);
        `CHK("guard write opcode", TL_ACK, dop)
        racc(1, 0, GUARD_BASE, '0);
        `CHK("guard opened", {8'h0F, 2'b00, lim[53:0]}, q)
        racc(1, 1, GUARD_BASE, 64'h0);
        racc(1, 0, GUARD_BASE, '0);
        `CHK("guard locked", {8'h0F, 2'b00, lim[53:0]}, q)
        macc(1, MEM_BASE + 64'h100, {8{32'hC3A5_0F1E}});
        `CHK("write granted", 1'b0, den)
        `CHK("write command", DFI_WR, cmd_seen)
        `CHK("write address", MEM_BASE + 64'h100, adr_seen)
        `CHK("write data", {8{32'hC3A5_0F1E}}, wd_seen)
        ra = '{MEM_BASE + 64'h20, MEM_BASE + 64'h0F_FFE0};
        foreach (ra[i]) begin
            macc(0, ra[i], '0);
            `CHK("read granted", 1'b0, den)
            `CHK("read command", DFI_RD, cmd_seen)
            `CHK("read data", {4{ra[i] ^ 64'h5A5A_5A5A_5A5A_5A5A}}, mq)
        end
        macc(0, MEM_BASE + 64'h10_0000, '0);
        `CHK("above top denied", 1'b1, den)
        `CHK("above top command", DFI_NOP, cmd_seen)
    endtask
    task automatic t_window();
        racc(1, 0, GUARD_BASE + GUARD_SPAN, '0);
        `CHK("guard outside", 1'b1, den)
        racc(0, 0, CTRL_BASE + CTRL_SPAN, '0);
        `CHK("control outside", 1'b1, den)
        racc(0, 0, CTRL_BASE + 64'h100, '0);
        `CHK("unmapped ack", 1'b0, den)
        `CHK("unmapped zero", 64'h0, q)
        ce = 1'b0;
        step();
        `CHK("frozen ready", 1'b0, r_ar[0])
        ce = 1'b1;
    endtask
    // ==========================================
    // Verdict, watchdog, main sequence
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Cuts a hang short
    initial begin
        #200000;
        mismatches++;
        end_of_test();
    end
    // Reset, then every scenario in turn
    initial begin
        {resetn, m_av, m_op, m_ad, m_wd} = '0;
        {ce, rdy, bm, src} = {2'b11, 8'hFF, 8'h00};
        foreach (r_av[i]) {r_av[i], r_op[i], r_ad[i], r_wd[i]} = '0;
        mismatches = 0;
        checks_done = 0;
        repeat (4) @(posedge core_clk);
        #1 resetn = 1'b1;
        t_reset();
        t_closed();
        t_init();
        t_refresh();
        t_guard();
        t_window();
        end_of_test();
    end
endmodule
